// ===== shared/sird_pkg.sv
// register map constants and types for the id, address and result bank
// assumes an external serial target engine supplies byte-wide accesses
// Contract
// R01: threshold select 0h, 1h or 3h: shared byte is second-channel offset.
// R02: threshold select 2h, angle off: shared byte is the z high limit.
// R03: strap pin picks address 34h gnd, 35h supply, 36h clock, 37h data.
// R04: host writes a 7-bit programmed address; the device keeps it.
// R05: address register bit 0 picks strap or programmed address.
// R06: version code reads in bits 3-2 of the id register; others read zero.
// R07: fixed 16-bit maker code, low byte at 0eh, high byte at 0fh.
// R08: temperature result per conversion; high 10h, low 11h, reset zero.
// R09: x result updates per conversion; high at 12h, low at 13h, reset zero.
// R10: y result updates per conversion; high at 14h, low at 15h, reset zero.
// R11: all results are signed two's complement across high and low bytes.
// R12: each result byte is 8 bits wide and read-only.
// R13: writes to read-only registers change nothing and have no side effect.
package sird_pkg;
    localparam logic [7:0] SIRD_OFS_SHARED    = 8'h0b;
    localparam logic [7:0] SIRD_OFS_ADDR_CFG  = 8'h0c;
    localparam logic [7:0] SIRD_OFS_VERSION   = 8'h0d;
    localparam logic [7:0] SIRD_OFS_MAKER_LO  = 8'h0e;
    localparam logic [7:0] SIRD_OFS_MAKER_HI  = 8'h0f;
    localparam logic [7:0] SIRD_OFS_TEMP_HI   = 8'h10;
    localparam logic [7:0] SIRD_OFS_TEMP_LO   = 8'h11;
    localparam logic [7:0] SIRD_OFS_X_HI      = 8'h12;
    localparam logic [7:0] SIRD_OFS_X_LO      = 8'h13;
    localparam logic [7:0] SIRD_OFS_Y_HI      = 8'h14;
    localparam logic [7:0] SIRD_OFS_Y_LO      = 8'h15;
    localparam logic [7:0] SIRD_RST_SHARED    = 8'h00;
    localparam logic [7:0] SIRD_RST_ADDR_CFG  = 8'h00;
    localparam logic [15:0] SIRD_RST_RESULT   = 16'h0000;
    localparam int          SIRD_ADDR_SRC_BIT = 0;
    localparam int          SIRD_VER_LSB      = 2;
    // maker code value is arbitrary
    localparam logic [15:0] SIRD_MAKER_CODE   = 16'h5a3c;
    localparam logic [1:0]  SIRD_THR_Z_HIGH   = 2'h2;
    localparam logic [1:0]  SIRD_ANGLE_OFF    = 2'h0;
    localparam logic [6:0]  SIRD_ADDR_GND     = 7'h34;
    localparam logic [6:0]  SIRD_ADDR_VCC     = 7'h35;
    localparam logic [6:0]  SIRD_ADDR_SCL     = 7'h36;
    localparam logic [6:0]  SIRD_ADDR_SDA     = 7'h37;
    typedef enum logic [1:0] {
        SIRD_STRAP_GND = 2'b00,
        SIRD_STRAP_VCC = 2'b01,
        SIRD_STRAP_SCL = 2'b10,
        SIRD_STRAP_SDA = 2'b11
    } sird_strap_t;
    typedef enum logic [1:0] {
        SIRD_CH_TEMP = 2'b00,
        SIRD_CH_X    = 2'b01,
        SIRD_CH_Y    = 2'b10,
        SIRD_CH_NONE = 2'b11
    } sird_chan_t;
endpackage

// ===== rtl/sird_strap_sync.sv
// two-stage synchroniser for the address strap pins
// assumes strap pins are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module sird_strap_sync (
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    input  wire logic [1:0]            strap_i,
    output var  sird_pkg::sird_strap_t strap_o
);
    import sird_pkg::*;
    logic [1:0] meta;
    logic [1:0] stable;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta   <= 2'h0;
            stable <= 2'h0;
        end else begin
            meta   <= strap_i;
            stable <= meta;
        end
    end
    assign strap_o = sird_strap_t'(stable);
endmodule // sird_strap_sync
`default_nettype wire

// ===== rtl/sird_result_reg.sv
// one 16-bit signed result held for byte reads
// assumes the conversion engine pulses load_i once per finished conversion
`timescale 1ns/100ps
`default_nettype none
module sird_result_reg (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic               load_i,
    input  wire logic signed [15:0] value_i,
    output logic signed [15:0]      value_o
);
    import sird_pkg::*;
    // no host write path exists, so writes can never disturb it
    always_ff @(posedge clk_i) begin
        if (reset_i)
            value_o <= SIRD_RST_RESULT; // R08
        else if (load_i)
            value_o <= value_i; // R11
    end
endmodule // sird_result_reg
`default_nettype wire

// ===== rtl/sird_regs.sv
// id, target address and result register bank of the magnetic sensor
// assumes a serial target engine issues one byte access per strobe
`timescale 1ns/100ps
`default_nettype none
module sird_regs (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic [7:0]         addr_i,
    input  wire logic [7:0]         wdata_i,
    output logic [7:0]              rdata_o,
    output logic                    rvalid_o,
    input  wire logic [1:0]         addr_strap_i,
    input  wire logic [1:0]         version_i,
    input  wire logic [1:0]         threshold_select_i,
    input  wire logic [1:0]         angle_enable_i,
    input  wire logic               result_load_i,
    input  wire sird_pkg::sird_chan_t result_chan_i,
    input  wire logic signed [15:0] result_value_i,
    output logic [6:0]              target_address_o,
    output logic [7:0]              second_offset_o,
    output logic                    second_offset_valid_o,
    output logic [7:0]              z_high_limit_o,
    output logic                    z_high_limit_valid_o
);
    import sird_pkg::*;

    logic [7:0]         second_offset_or_z_high_limit;
    logic [7:0]         target_address_config;
    logic [1:0]         version_code;
    logic               version_taken;
    sird_strap_t        strap;
    logic [6:0]         strap_address;
    logic [6:0]         next_target_address;
    logic               z_mode;
    logic [7:0]         next_rdata;
    logic signed [15:0] res [3];
    logic [2:0]         res_load;

    sird_strap_sync u_strap (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .strap_i (addr_strap_i),
        .strap_o (strap)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_res
            assign res_load[gi] = result_load_i
                && (result_chan_i == sird_chan_t'(gi)); // R08 R09 R10
            sird_result_reg u_res (
                .clk_i   (clk_i),
                .reset_i (reset_i),
                .load_i  (res_load[gi]),
                .value_i (result_value_i),
                .value_o (res[gi])
            );
        end
    endgenerate

    // byte selector used for both halves of every result
    function automatic logic [7:0] pick_byte(input logic [15:0] v,
                                             input logic hi);
        pick_byte = hi ? v[15:8] : v[7:0];
    endfunction

    // writable registers; all other offsets ignore writes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            second_offset_or_z_high_limit <= SIRD_RST_SHARED;
            target_address_config         <= SIRD_RST_ADDR_CFG;
        end else if (wr_i) begin
            if (addr_i == SIRD_OFS_SHARED)
                second_offset_or_z_high_limit <= wdata_i;
            if (addr_i == SIRD_OFS_ADDR_CFG)
                target_address_config <= wdata_i; // R04 R13
        end
    end

    // version strap caught once after reset release, then fixed
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            version_code  <= 2'h0;
            version_taken <= 1'b0;
        end else if (!version_taken) begin
            version_code  <= version_i; // R06
            version_taken <= 1'b1;
        end
    end

    always_comb begin
        unique case (strap)
            SIRD_STRAP_GND: strap_address = SIRD_ADDR_GND; // R03
            SIRD_STRAP_VCC: strap_address = SIRD_ADDR_VCC;
            SIRD_STRAP_SCL: strap_address = SIRD_ADDR_SCL;
            SIRD_STRAP_SDA: strap_address = SIRD_ADDR_SDA;
        endcase
    end

    always_comb begin
        if (target_address_config[SIRD_ADDR_SRC_BIT]) // R05
            next_target_address = target_address_config[7:1];
        else
            next_target_address = strap_address;
    end

    // registered so a strap glitch never reaches the bus engine directly
    always_ff @(posedge clk_i) begin
        if (reset_i)
            target_address_o <= SIRD_ADDR_GND;
        else
            target_address_o <= next_target_address;
    end

    assign z_mode = (threshold_select_i == SIRD_THR_Z_HIGH)
                 && (angle_enable_i == SIRD_ANGLE_OFF); // R02

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            second_offset_o       <= 8'h00;
            second_offset_valid_o <= 1'b0;
            z_high_limit_o        <= 8'h00;
            z_high_limit_valid_o  <= 1'b0;
        end else begin
            // threshold select 2h with angle on selects neither use
            second_offset_valid_o <= threshold_select_i
                != SIRD_THR_Z_HIGH; // R01
            second_offset_o       <= second_offset_or_z_high_limit;
            z_high_limit_valid_o  <= z_mode; // R02
            z_high_limit_o        <= second_offset_or_z_high_limit;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_i)
            SIRD_OFS_SHARED:   next_rdata = second_offset_or_z_high_limit;
            SIRD_OFS_ADDR_CFG: next_rdata = target_address_config;
            SIRD_OFS_VERSION:
                next_rdata = {4'h0, version_code, 2'h0}; // R06
            SIRD_OFS_MAKER_LO: next_rdata = SIRD_MAKER_CODE[7:0]; // R07
            SIRD_OFS_MAKER_HI: next_rdata = SIRD_MAKER_CODE[15:8]; // R07
            SIRD_OFS_TEMP_HI:  next_rdata = pick_byte(res[0], 1'b1); // R08
            SIRD_OFS_TEMP_LO:  next_rdata = pick_byte(res[0], 1'b0); // R08
            SIRD_OFS_X_HI:     next_rdata = pick_byte(res[1], 1'b1); // R09
            SIRD_OFS_X_LO:     next_rdata = pick_byte(res[1], 1'b0); // R09
            SIRD_OFS_Y_HI:     next_rdata = pick_byte(res[2], 1'b1); // R10
            SIRD_OFS_Y_LO:     next_rdata = pick_byte(res[2], 1'b0); // R10
            default:           next_rdata = 8'h00; // R12
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i)
                rdata_o <= next_rdata;
        end
    end

    property p_addr_src;
        @(posedge clk_i) disable iff (reset_i)
        target_address_config[SIRD_ADDR_SRC_BIT] |=>
            target_address_o == $past(target_address_config[7:1]);
    endproperty
    a_addr_src: assert property (p_addr_src) // R05
        else $error("programmed address not used");

    property p_strap_addr;
        @(posedge clk_i) disable iff (reset_i)
        !target_address_config[SIRD_ADDR_SRC_BIT] && $stable(strap) |=>
            target_address_o == {5'h0d, $past(strap)};
    endproperty
    a_strap_addr: assert property (p_strap_addr) // R03
        else $error("strap address wrong");

    property p_addr_store;
        @(posedge clk_i) disable iff (reset_i)
        wr_i && addr_i == SIRD_OFS_ADDR_CFG |=>
            target_address_config == $past(wdata_i);
    endproperty
    a_addr_store: assert property (p_addr_store) // R04
        else $error("address write lost");

    sequence s_read_maker_lo;
        rd_i && addr_i == SIRD_OFS_MAKER_LO;
    endsequence
    property p_maker;
        @(posedge clk_i) disable iff (reset_i)
        s_read_maker_lo |=> rvalid_o && rdata_o == SIRD_MAKER_CODE[7:0];
    endproperty
    a_maker: assert property (p_maker) // R07
        else $error("maker code low byte wrong");

    property p_version;
        @(posedge clk_i) disable iff (reset_i)
        rd_i && addr_i == SIRD_OFS_VERSION |=>
            rdata_o[7:4] == 4'h0 && rdata_o[1:0] == 2'h0;
    endproperty
    a_version: assert property (p_version) // R06
        else $error("version reserved bits set");

    sequence s_temp_load;
        result_load_i && result_chan_i == SIRD_CH_TEMP;
    endsequence
    property p_temp_read;
        @(posedge clk_i) disable iff (reset_i)
        rd_i && addr_i == SIRD_OFS_TEMP_HI |=>
            rdata_o == $past(res[0][15:8]);
    endproperty
    a_temp_read: assert property (p_temp_read) // R08
        else $error("temperature high byte wrong");

    property p_x_load;
        @(posedge clk_i) disable iff (reset_i)
        result_load_i && result_chan_i == SIRD_CH_X |=>
            res[1] == $past(result_value_i);
    endproperty
    a_x_load: assert property (p_x_load) // R09
        else $error("x result not stored");

    property p_y_load;
        @(posedge clk_i) disable iff (reset_i)
        result_load_i && result_chan_i == SIRD_CH_Y |=>
            res[2] == $past(result_value_i);
    endproperty
    a_y_load: assert property (p_y_load) // R10
        else $error("y result not stored");

    property p_temp_load;
        @(posedge clk_i) disable iff (reset_i)
        s_temp_load |=> res[0] == $past(result_value_i)
            && res[1] == $past(res[1]) && res[2] == $past(res[2]);
    endproperty
    a_temp_load: assert property (p_temp_load) // R08
        else $error("temperature load wrong");

    property p_ro_write;
        @(posedge clk_i) disable iff (reset_i)
        wr_i && !result_load_i |=> $stable(res[0]) && $stable(res[1])
            && $stable(res[2]);
    endproperty
    a_ro_write: assert property (p_ro_write) // R13
        else $error("write changed a result");

    property p_zmode;
        @(posedge clk_i) disable iff (reset_i)
        z_mode |=> z_high_limit_valid_o && !second_offset_valid_o;
    endproperty
    a_zmode: assert property (p_zmode) // R02
        else $error("z limit mode wrong");

    property p_offset;
        @(posedge clk_i) disable iff (reset_i)
        threshold_select_i != SIRD_THR_Z_HIGH |=>
            second_offset_valid_o && !z_high_limit_valid_o;
    endproperty
    a_offset: assert property (p_offset) // R01
        else $error("offset mode wrong");
endmodule // sird_regs
`default_nettype wire

// ===== tb/sird_host_model.sv
// host side model: byte reads and writes on the strobe port of the bank
// assumes clk_i from the bench; one request per cycle, back to back allowed
`timescale 1ns/100ps
`default_nettype none
module sird_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // strobe left high so a following request needs no second edge
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        rd_o = 1'b0;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
        wr_o = 1'b0;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        v = rvalid_i;
        d = rdata_i;
    endtask
    // idle bus flips so a stale value is never mistaken for a fresh one
    task automatic idle();
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
        @(posedge clk_i);
        #1;
    endtask
endmodule // sird_host_model
`default_nettype wire

// ===== tb/sird_regs_tb.sv
// self-checking bench for the id, address and result bank
// assumes the host model drives the strobe port; results loaded directly
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module sird_regs_tb;
    import sird_pkg::*;
    logic               clk_i;
    logic               reset_i;
    logic               wr_i;
    logic               rd_i;
    logic [7:0]         addr_i;
    logic [7:0]         wdata_i;
    logic [7:0]         rdata_o;
    logic               rvalid_o;
    logic [1:0]         addr_strap_i;
    logic [1:0]         version_i;
    logic [1:0]         threshold_select_i;
    logic [1:0]         angle_enable_i;
    logic               result_load_i;
    sird_chan_t         result_chan_i;
    logic signed [15:0] result_value_i;
    logic [6:0]         target_address_o;
    logic [7:0]         second_offset_o;
    logic               second_offset_valid_o;
    logic [7:0]         z_high_limit_o;
    logic               z_high_limit_valid_o;
    int                 err_count = 0;
    int                 checks = 0;
    int                 cycles = 0;
    int                 seed = 32'h6280;
    int                 shared_m = 0;
    int                 cfg_m = 0;
    int                 res_m[3] = '{0, 0, 0};
    logic [7:0]         d;
    logic               v;

    sird_regs u_sird_regs (.clk_i(clk_i), .reset_i(reset_i), .wr_i(wr_i),
        .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .addr_strap_i(addr_strap_i),
        .version_i(version_i), .threshold_select_i(threshold_select_i),
        .angle_enable_i(angle_enable_i), .result_load_i(result_load_i),
        .result_chan_i(result_chan_i), .result_value_i(result_value_i),
        .target_address_o(target_address_o),
        .second_offset_o(second_offset_o),
        .second_offset_valid_o(second_offset_valid_o),
        .z_high_limit_o(z_high_limit_o),
        .z_high_limit_valid_o(z_high_limit_valid_o));
    sird_host_model u_sird_host_model (.clk_i(clk_i), .rdata_i(rdata_o),
        .rvalid_i(rvalid_o), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
        .wdata_o(wdata_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end

    function automatic logic [7:0] exp_byte(input int a);
        case (a)
            11: exp_byte = 8'(shared_m);
            12: exp_byte = 8'(cfg_m);
            13: exp_byte = {4'h0, version_i, 2'h0};
            14: exp_byte = SIRD_MAKER_CODE[7:0];
            15: exp_byte = SIRD_MAKER_CODE[15:8];
            16, 17, 18, 19, 20, 21:
                exp_byte = 8'(res_m[(a - 16) / 2] >> ((a % 2) ? 0 : 8));
            default: exp_byte = 8'h00;
        endcase
    endfunction
    task automatic rd_chk(input int a);
        u_sird_host_model.read(8'(a), d, v);
        `CHK(v, 1'b1)
        `CHK(d, exp_byte(a))
    endtask
    task automatic idle(input int n);
        repeat (n) u_sird_host_model.idle();
    endtask
    task automatic load(input sird_chan_t c, input logic signed [15:0] x);
        result_load_i = 1'b1;
        result_chan_i = c;
        result_value_i = x;
        @(posedge clk_i);
        #1;
        result_load_i = 1'b0;
        if (c != SIRD_CH_NONE) res_m[c] = int'(x);
        idle(1);
    endtask
    task automatic final_report();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        reset_i = 1'b1;
        addr_strap_i = 2'h0;
        version_i = 2'h2;
        threshold_select_i = 2'h0;
        angle_enable_i = 2'h0;
        result_load_i = 1'b0;
        result_chan_i = SIRD_CH_NONE;
        result_value_i = '0;
        repeat (16) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        idle(3);
        for (int a = 11; a <= 22; a++) rd_chk(a);
        rd_chk(8'h30);
        `CHK(target_address_o, 7'h34)
        $display("test reset values done");
        // strap settles through the synchroniser in three edges
        for (int s = 0; s < 4; s++) begin
            addr_strap_i = 2'(s);
            idle(3);
            `CHK(target_address_o, 7'(8'h34 + s))
        end
        $display("test strap address done");
        for (int i = 0; i < 4; i++) begin
            cfg_m = ({$random(seed)} & 'hfe) | (i & 1);
            u_sird_host_model.write(8'h0c, 8'(cfg_m));
            idle(1);
            `CHK(target_address_o, cfg_m[0] ? 7'(cfg_m >> 1) : 7'h37)
            rd_chk(12);
        end
        $display("test programmed address done");
        shared_m = {$random(seed)} % 256;
        u_sird_host_model.write(8'h0b, 8'(shared_m));
        for (int t = 0; t < 16; t++) begin
            threshold_select_i = 2'(t >> 2);
            angle_enable_i = 2'(t);
            idle(2);
            `CHK(second_offset_valid_o, 1'((t >> 2) != 2))
            `CHK(z_high_limit_valid_o, 1'(t == 8))
            if ((t >> 2) != 2) `CHK(second_offset_o, 8'(shared_m))
            if (t == 8) `CHK(z_high_limit_o, 8'(shared_m))
        end
        rd_chk(11);
        $display("test shared byte done");
        for (int i = 0; i < 12; i++) begin
            load(sird_chan_t'(i % 4), 16'($random(seed)));
            for (int a = 16; a <= 21; a++) rd_chk(a);
        end
        $display("test results done");
        for (int a = 13; a <= 22; a++) begin
            u_sird_host_model.write(8'(a), 8'(~a));
        end
        for (int a = 11; a <= 22; a++) rd_chk(a);
        $display("test read-only writes done");
        // second reset: registers back to zero, target address to 34h, version caught afresh
        reset_i = 1'b1;
        version_i = 2'h0;
        idle(2);
        reset_i = 1'b0;
        shared_m = 0;
        cfg_m = 0;
        res_m = '{0, 0, 0};
        `CHK(target_address_o, 7'h34)
        for (int a = 11; a <= 22; a++) rd_chk(a);
        `CHK(target_address_o, 7'h37)
        $display("test mid-run reset done");
        idle(2);
        final_report();
    end
endmodule // sird_regs_tb
`undef CHK
`default_nettype wire
